// ===== core/aer_pkg.sv
// Behaviour
// (RL1) Severity bit one makes an uncorrectable class fatal, zero makes it nonfatal.
// (RL2) Severity register lives at extended config offset 10Ch, 32 bits, mixed access.
// (RL3) Severity register resets to 0006 2031h on fundamental reset.
// (RL4) Severity bits 20 to 12 and 4 are read/write, one per class.
// (RL5) Reserved severity bits 5 and 0 are read-only and read as one.
// (RL6) Reserved severity ranges 31:21, 11:6 and 3:1 read as zero.
// (RL7) Sticky bits clear only on fundamental reset, from PCIe or global reset.
// (RL8) Correctable status register at offset 110h, 32 bits, resets to zero.
// (RL9) Status flags clear only on a written one; a zero leaves them.
// (RL10) Status bit 13 sets when an advisory nonfatal error is reported.
// (RL11) Status bit 12 sets when the retransmit timer expires.
// (RL12) Status bit 8 sets when the retransmit attempt counter wraps.
// (RL13) Status bit 7 sets on a coding error inside a link packet.
// (RL14) Status bit 6 sets on a coding error inside a transaction packet.
// (RL15) Status bit 0 sets on any coding error at all.
// (RL16) Reserved status ranges 31:14, 11:9 and 5:1 read as zero.
// (RL17) A set correctable mask bit blocks the flag and the message.
// (RL18) An unmasked uncorrectable error picks fatal or nonfatal from its severity bit.
package aer_pkg;

	// Register offsets in extended configuration space
	localparam logic [11:0] AER_SEV_OFFSET    = 12'h10c;
	localparam logic [11:0] AER_STATUS_OFFSET = 12'h110;

	// Severity register layout
	localparam logic [31:0] AER_SEV_RESET   = 32'h0006_2011;
	localparam logic [31:0] AER_SEV_WR_MASK = 32'h001f_f010;
	localparam logic [31:0] AER_SEV_RO_ONES = 32'h0000_0021;

	// Correctable status layout
	localparam logic [31:0] AER_STS_RESET     = 32'h0000_0000;
	localparam logic [31:0] AER_STS_IMPL_MASK = 32'h0000_31c1;
	localparam int          AER_STS_ADVISORY  = 13;
	localparam int          AER_STS_RETX_TMO  = 12;
	localparam int          AER_STS_RETX_WRAP = 8;
	localparam int          AER_STS_LINK_CODE = 7;
	localparam int          AER_STS_TXN_CODE  = 6;
	localparam int          AER_STS_RX_CODE   = 0;

	// Configuration access request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} aer_cfg_req_s;

	// Correctable error events, one-cycle pulses
	typedef struct packed {
		logic advisory_nonfatal;
		logic retransmit_timer_expired;
		logic retransmit_wrap;
		logic link_packet_code_error;
		logic transaction_packet_code_error;
		logic receiver_code_error;
	} aer_corr_evt_s;

	// Expand byte enables into a bit mask
	function automatic logic [31:0] aer_be_mask(input logic [3:0] be);
		aer_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : aer_be_mask

endpackage : aer_pkg

// ===== core/aer_sev_corr_regs.sv
`timescale 1ns/1ns
`default_nettype none
module aer_sev_corr_regs (
	input  wire logic                   sys_clk,          // 25 MHz clock
	input  wire logic                   rst_n,            // Ordinary reset, active low
	input  wire logic                   pcie_reset_n,     // PCIe reset, active low
	input  wire logic                   global_reset_n,   // Global reset, active low
	input  wire aer_pkg::aer_cfg_req_s  cfg_req,          // Config access request
	input  wire aer_pkg::aer_corr_evt_s corr_evt,         // Correctable error pulses
	input  wire logic [31:0]            corr_mask,        // Correctable mask bits
	input  wire logic [31:0]            uncorr_evt,       // Uncorrectable error pulses
	input  wire logic [31:0]            uncorr_mask,      // Uncorrectable mask bits
	output var  logic [31:0]            cfg_rdata,        // Read data
	output var  logic                   cfg_rvalid,       // Read data valid pulse
	output var  logic [31:0]            severity,         // Current severity view
	output var  logic [31:0]            corr_status,      // Current status view
	output var  logic                   msg_fatal,        // Fatal message pulse
	output var  logic                   msg_nonfatal,     // Nonfatal message pulse
	output var  logic                   msg_correctable   // Correctable message pulse
);

	// Fundamental reset follows either reset input
	wire logic fundamental_reset_n = pcie_reset_n & global_reset_n; // RL7
	wire logic core_rst_n          = rst_n & fundamental_reset_n;

	logic [31:0] sev_reg;
	logic [31:0] sev_next;
	logic        adv_reg;
	logic        adv_next;
	logic [31:0] sticky_reg;
	logic [31:0] sticky_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        rvalid_reg;
	logic        fatal_reg;
	logic        fatal_next;
	logic        nonfatal_reg;
	logic        nonfatal_next;
	logic        corr_msg_reg;
	logic        corr_msg_next;
	logic [31:0] sev_out_reg;
	logic [31:0] sts_out_reg;

	// Address decode and byte lane mask
	wire logic        hit_sev   = cfg_req.addr == aer_pkg::AER_SEV_OFFSET;    // RL2
	wire logic        hit_sts   = cfg_req.addr == aer_pkg::AER_STATUS_OFFSET; // RL8
	wire logic [31:0] lane_mask = aer_pkg::aer_be_mask(cfg_req.be);
	wire logic        wr_sev    = cfg_req.wr & hit_sev;
	wire logic        wr_sts    = cfg_req.wr & hit_sts;

	// Severity view: stored writable bits plus fixed ones
	wire logic [31:0] sev_view = (sev_reg & aer_pkg::AER_SEV_WR_MASK)
		| aer_pkg::AER_SEV_RO_ONES;                                          // RL5 RL6

	// Raw correctable events mapped to status positions
	wire logic [31:0] corr_raw = ({31'h0000_0000, corr_evt.advisory_nonfatal}
		<< aer_pkg::AER_STS_ADVISORY)                                        // RL10
		| ({31'h0000_0000, corr_evt.retransmit_timer_expired}
		<< aer_pkg::AER_STS_RETX_TMO)                                        // RL11
		| ({31'h0000_0000, corr_evt.retransmit_wrap}
		<< aer_pkg::AER_STS_RETX_WRAP)                                       // RL12
		| ({31'h0000_0000, corr_evt.link_packet_code_error}
		<< aer_pkg::AER_STS_LINK_CODE)                                       // RL13
		| ({31'h0000_0000, corr_evt.transaction_packet_code_error}
		<< aer_pkg::AER_STS_TXN_CODE)                                        // RL14
		| ({31'h0000_0000, corr_evt.receiver_code_error
		| corr_evt.link_packet_code_error
		| corr_evt.transaction_packet_code_error}
		<< aer_pkg::AER_STS_RX_CODE);                                        // RL15

	// Masked classes neither flag nor report
	wire logic [31:0] corr_set = corr_raw & ~corr_mask
		& aer_pkg::AER_STS_IMPL_MASK;                                        // RL17

	// Write-one-to-clear bits; a zero leaves the flag alone
	wire logic [31:0] corr_clr = wr_sts ? (cfg_req.wdata & lane_mask) : 32'h0000_0000; // RL9

	// Status view, reserved bits forced to zero
	wire logic [31:0] sts_view = ((sticky_reg
		& ~(32'h0000_0001 << aer_pkg::AER_STS_ADVISORY))
		| ({31'h0000_0000, adv_reg} << aer_pkg::AER_STS_ADVISORY))
		& aer_pkg::AER_STS_IMPL_MASK;                                        // RL16

	// Unmasked uncorrectable classes split by severity
	wire logic [31:0] uncorr_live = uncorr_evt & ~uncorr_mask & aer_pkg::AER_SEV_WR_MASK;

	// Next severity: enabled byte lanes of writable bits only
	always_comb begin
		sev_next = sev_reg;
		if (wr_sev) begin
			sev_next = (sev_reg & ~(lane_mask & aer_pkg::AER_SEV_WR_MASK))
				| (cfg_req.wdata & lane_mask & aer_pkg::AER_SEV_WR_MASK); // RL4
		end
	end

	// Next status: set wins over a clear in the same cycle
	always_comb begin
		sticky_next = ((sticky_reg & ~corr_clr) | corr_set) & aer_pkg::AER_STS_IMPL_MASK;
		adv_next    = (adv_reg & ~corr_clr[aer_pkg::AER_STS_ADVISORY])
			| corr_set[aer_pkg::AER_STS_ADVISORY];                   // RL10
	end

	// Read mux and message selection
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (hit_sev) begin
			rdata_next = sev_view;
		end else if (hit_sts) begin
			rdata_next = sts_view;
		end
		fatal_next    = |(uncorr_live & sev_view);                   // RL1 RL18
		nonfatal_next = |(uncorr_live & ~sev_view);                  // RL1 RL18
		corr_msg_next = |corr_set;                                   // RL17
	end

	// Severity holds its value across ordinary resets
	always_ff @(posedge sys_clk or negedge fundamental_reset_n) begin
		if (!fundamental_reset_n) begin
			sev_reg <= aer_pkg::AER_SEV_RESET;                           // RL3 RL7
		end else begin
			sev_reg <= sev_next;
		end
	end

	// Sticky status flags, fundamental reset only
	always_ff @(posedge sys_clk or negedge fundamental_reset_n) begin
		if (!fundamental_reset_n) begin
			sticky_reg <= aer_pkg::AER_STS_RESET;                        // RL7 RL8
		end else begin
			sticky_reg <= sticky_next;
		end
	end

	// Advisory flag is not sticky
	always_ff @(posedge sys_clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			adv_reg <= 1'b0;
		end else begin
			adv_reg <= adv_next;
		end
	end

	// Read answer one cycle after the request
	always_ff @(posedge sys_clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			rdata_reg  <= 32'h0000_0000;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= cfg_req.rd;
			if (cfg_req.rd) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	// Message pulses and exported views
	always_ff @(posedge sys_clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			fatal_reg    <= 1'b0;
			nonfatal_reg <= 1'b0;
			corr_msg_reg <= 1'b0;
			sev_out_reg  <= aer_pkg::AER_SEV_RESET | aer_pkg::AER_SEV_RO_ONES;
			sts_out_reg  <= aer_pkg::AER_STS_RESET;
		end else begin
			fatal_reg    <= fatal_next;
			nonfatal_reg <= nonfatal_next;
			corr_msg_reg <= corr_msg_next;
			sev_out_reg  <= sev_view;
			sts_out_reg  <= sts_view;
		end
	end

	// Outputs straight from flops
	assign cfg_rdata       = rdata_reg;
	assign cfg_rvalid      = rvalid_reg;
	assign severity        = sev_out_reg;
	assign corr_status     = sts_out_reg;
	assign msg_fatal       = fatal_reg;
	assign msg_nonfatal    = nonfatal_reg;
	assign msg_correctable = corr_msg_reg;

	// Helper: first cycle after fundamental reset; ordinary reset keeps it
	logic chk_run_reg;
	always_ff @(posedge sys_clk or negedge fundamental_reset_n) begin
		if (!fundamental_reset_n) begin
			chk_run_reg <= 1'b0;
		end else begin
			chk_run_reg <= 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!core_rst_n);

	// Fatal chosen when the class severity is one
	property p_fatal_pick;
		(|(uncorr_live & sev_view)) |=> msg_fatal;
	endproperty
	a_fatal_pick: assert property (p_fatal_pick) else $error("fatal message missing"); // RL1

	// Nonfatal only when some live class has severity zero
	property p_nonfatal_pick;
		msg_nonfatal |-> $past(|(uncorr_live & ~sev_view));
	endproperty
	a_nonfatal_pick: assert property (p_nonfatal_pick) else $error("bad nonfatal message"); // RL18

	// Severity read returns the register view
	property p_sev_read;
		(cfg_req.rd && hit_sev) |=> (cfg_rvalid && cfg_rdata == $past(sev_view));
	endproperty
	a_sev_read: assert property (p_sev_read) else $error("severity read wrong"); // RL2

	// Reset value seen in the first cycle
	property p_sev_reset;
		(!chk_run_reg && !$past(wr_sev)) |-> ((sev_reg & aer_pkg::AER_SEV_WR_MASK)
			== (aer_pkg::AER_SEV_RESET & aer_pkg::AER_SEV_WR_MASK));
	endproperty
	a_sev_reset: assert property (p_sev_reset) else $error("severity reset value wrong"); // RL3

	// Full-word write lands in the writable bits
	property p_sev_write;
		(wr_sev && cfg_req.be == 4'hf) |=> ((sev_view & aer_pkg::AER_SEV_WR_MASK)
			== ($past(cfg_req.wdata) & aer_pkg::AER_SEV_WR_MASK));
	endproperty
	a_sev_write: assert property (p_sev_write) else $error("severity write lost"); // RL4

	// Fixed bits of the severity answer
	property p_sev_fixed;
		(cfg_req.rd && hit_sev) ##1 cfg_rvalid |->
			((cfg_rdata & ~aer_pkg::AER_SEV_WR_MASK) == aer_pkg::AER_SEV_RO_ONES);
	endproperty
	a_sev_fixed: assert property (p_sev_fixed) else $error("severity reserved bits wrong"); // RL5

	// Status reads zero in the first cycle after fundamental reset unless an event came
	property p_sts_reset;
		(!chk_run_reg && !$past(|corr_set)) |-> (sts_view == aer_pkg::AER_STS_RESET);
	endproperty
	a_sts_reset: assert property (p_sts_reset) else $error("status reset value wrong"); // RL8

	// Written one clears when no event, written zero keeps
	property p_sts_w1c;
		(wr_sts && cfg_req.be == 4'hf && corr_set == 32'h0000_0000) |=>
			(sts_view == ($past(sts_view) & ~$past(cfg_req.wdata)));
	endproperty
	a_sts_w1c: assert property (p_sts_w1c) else $error("write-one-clear wrong"); // RL9

	// Retransmit timeout sets bit 12 and holds it one more cycle unless cleared
	property p_retx_tmo;
		(corr_evt.retransmit_timer_expired && !corr_mask[aer_pkg::AER_STS_RETX_TMO])
			|=> sts_view[aer_pkg::AER_STS_RETX_TMO] ##1 (sts_view[aer_pkg::AER_STS_RETX_TMO]
			|| $past(corr_clr[aer_pkg::AER_STS_RETX_TMO]));
	endproperty
	a_retx_tmo: assert property (p_retx_tmo) else $error("timeout flag not held"); // RL11

	// Link packet coding error sets the receiver bit and bit 7
	property p_rx_code;
		(corr_evt.link_packet_code_error && !corr_mask[aer_pkg::AER_STS_RX_CODE])
			|=> sts_view[aer_pkg::AER_STS_RX_CODE] && sts_view[aer_pkg::AER_STS_LINK_CODE]
			|| corr_mask[aer_pkg::AER_STS_LINK_CODE];
	endproperty
	a_rx_code: assert property (p_rx_code) else $error("coding error flags missing"); // RL15

	// Masked wrap event neither flags nor reports
	property p_mask_wrap;
		(corr_mask == 32'hffff_ffff && !sts_view[aer_pkg::AER_STS_RETX_WRAP])
			|=> !sts_view[aer_pkg::AER_STS_RETX_WRAP] && !msg_correctable;
	endproperty
	a_mask_wrap: assert property (p_mask_wrap) else $error("masked event leaked"); // RL17

	// Reserved status bits stay zero on read
	property p_sts_rsvd;
		(cfg_req.rd && hit_sts) |=> ((cfg_rdata & ~aer_pkg::AER_STS_IMPL_MASK) == 32'h0);
	endproperty
	a_sts_rsvd: assert property (p_sts_rsvd) else $error("status reserved bits set"); // RL16

	// Reserved severity ranges read as zero
	property p_sev_rsvd;
		(cfg_req.rd && hit_sev) |=> ((cfg_rdata
			& ~(aer_pkg::AER_SEV_WR_MASK | aer_pkg::AER_SEV_RO_ONES)) == 32'h0000_0000);
	endproperty
	a_sev_rsvd: assert property (p_sev_rsvd) else $error("severity reserved bits set"); // RL6

	// Severity moves only on a write
	property p_sev_sticky;
		!wr_sev |=> (sev_reg == $past(sev_reg));
	endproperty
	a_sev_sticky: assert property (p_sev_sticky) else $error("severity changed unwritten"); // RL7

	// Advisory event sets bit 13
	property p_adv_set;
		(corr_evt.advisory_nonfatal && !corr_mask[aer_pkg::AER_STS_ADVISORY])
			|=> sts_view[aer_pkg::AER_STS_ADVISORY];
	endproperty
	a_adv_set: assert property (p_adv_set) else $error("advisory flag not set"); // RL10

	// Attempt counter wrap sets bit 8
	property p_wrap_set;
		(corr_evt.retransmit_wrap && !corr_mask[aer_pkg::AER_STS_RETX_WRAP])
			|=> sts_view[aer_pkg::AER_STS_RETX_WRAP];
	endproperty
	a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not set"); // RL12

	// Link packet coding error sets bit 7
	property p_link_set;
		(corr_evt.link_packet_code_error && !corr_mask[aer_pkg::AER_STS_LINK_CODE])
			|=> sts_view[aer_pkg::AER_STS_LINK_CODE];
	endproperty
	a_link_set: assert property (p_link_set) else $error("link code flag not set"); // RL13

	// Transaction packet coding error sets bit 6
	property p_txn_set;
		(corr_evt.transaction_packet_code_error && !corr_mask[aer_pkg::AER_STS_TXN_CODE])
			|=> sts_view[aer_pkg::AER_STS_TXN_CODE];
	endproperty
	a_txn_set: assert property (p_txn_set) else $error("packet code flag not set"); // RL14

	// Flags drop only where a one is written
	property p_sts_keep;
		(sts_view != 32'h0000_0000) |=>
			((($past(sts_view) & ~$past(corr_clr)) & ~sts_view) == 32'h0000_0000);
	endproperty
	a_sts_keep: assert property (p_sts_keep) else $error("status flag lost"); // RL9

	// Unmasked correctable event sends the message
	property p_corr_msg;
		(|corr_set) |=> msg_correctable;
	endproperty
	a_corr_msg: assert property (p_corr_msg) else $error("correctable message missing"); // RL17

	// Masked or reserved uncorrectable bits send nothing
	property p_uncorr_quiet;
		((uncorr_evt & ~uncorr_mask & aer_pkg::AER_SEV_WR_MASK) == 32'h0000_0000)
			|=> (!msg_fatal && !msg_nonfatal);
	endproperty
	a_uncorr_quiet: assert property (p_uncorr_quiet) else $error("stray error message"); // RL18

	// Main scenarios
	c_fatal_msg: cover property (msg_fatal);
	c_nonfatal_msg: cover property (msg_nonfatal);
	c_set_and_clear: cover property (wr_sts && |(corr_clr & corr_set));
	c_status_read: cover property ((cfg_req.rd && hit_sts) ##1 (cfg_rdata != 32'h0));
	c_masked_event: cover property (|(corr_raw & corr_mask));

endmodule : aer_sev_corr_regs
`default_nettype wire

// ===== verif/tb_pcie_aer_severity_corr_status.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pcie_aer_severity_corr_status;
	logic                   sys_clk;
	logic                   rst_n;
	logic                   pcie_reset_n;
	logic                   global_reset_n;
	aer_pkg::aer_cfg_req_s  cfg_req;
	aer_pkg::aer_corr_evt_s corr_evt;
	logic [31:0]            corr_mask;
	logic [31:0]            uncorr_evt;
	logic [31:0]            uncorr_mask;
	logic [31:0]            cfg_rdata;
	logic                   cfg_rvalid;
	logic [31:0]            severity;
	logic [31:0]            corr_status;
	logic                   msg_fatal;
	logic                   msg_nonfatal;
	logic                   msg_correctable;
	int                     failures;
	int                     check_count;
	int                     cycles;
	integer                 seed;
	logic [31:0]            exp_sev;
	logic [31:0]            exp_sts;
	logic [31:0]            w;
	logic [31:0]            u;
	logic [31:0]            s;
	logic [3:0]             b;
	logic [5:0]             ev;

	aer_sev_corr_regs dut (
		.sys_clk         (sys_clk),
		.rst_n           (rst_n),
		.pcie_reset_n    (pcie_reset_n),
		.global_reset_n  (global_reset_n),
		.cfg_req         (cfg_req),
		.corr_evt        (corr_evt),
		.corr_mask       (corr_mask),
		.uncorr_evt      (uncorr_evt),
		.uncorr_mask     (uncorr_mask),
		.cfg_rdata       (cfg_rdata),
		.cfg_rvalid      (cfg_rvalid),
		.severity        (severity),
		.corr_status     (corr_status),
		.msg_fatal       (msg_fatal),
		.msg_nonfatal    (msg_nonfatal),
		.msg_correctable (msg_correctable)
	);

	// Free running clock
	always #20 sys_clk = ~sys_clk;

	// Byte enables to bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		for (int i = 0; i < 32; i++) lane_mask[i] = be[i / 8];
	endfunction : lane_mask

	// Severity after a write
	function automatic logic [31:0] sev_next(input logic [31:0] o, input logic [31:0] d,
			input logic [3:0] be);
		logic [31:0] m;
		m = aer_pkg::AER_SEV_WR_MASK & lane_mask(be);
		sev_next = (o & ~m) | (d & m) | aer_pkg::AER_SEV_RO_ONES;
	endfunction : sev_next

	// Status bits raised by an event set
	function automatic logic [31:0] evt_bits(input logic [5:0] e, input logic [31:0] m);
		logic [31:0] r;
		r = '0;
		r[13] = e[5];
		r[12] = e[4];
		r[8] = e[3];
		r[7] = e[2];
		r[6] = e[1];
		r[0] = |e[2:0];
		evt_bits = r & ~m;
	endfunction : evt_bits

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic end_of_test;
		if (failures == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic cfg_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge sys_clk);
		#1;
		cfg_req = '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
		@(posedge sys_clk);
		#1;
		cfg_req.wr = 1'b0;
	endtask : cfg_write

	task automatic cfg_read_chk(input logic [11:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		#1;
		cfg_req.rd = 1'b1;
		cfg_req.addr = a;
		@(posedge sys_clk);
		#1;
		cfg_req.rd = 1'b0;
		chk("cfg_rvalid", 32'h1, {31'h0, cfg_rvalid});
		chk("cfg_rdata", exp, cfg_rdata);
	endtask : cfg_read_chk

	// One-cycle event pulses; message outputs settle by return
	task automatic pulse(input logic [5:0] e, input logic [31:0] ue);
		@(posedge sys_clk);
		#1;
		corr_evt = e;
		uncorr_evt = ue;
		@(posedge sys_clk);
		#1;
		corr_evt = '0;
		uncorr_evt = '0;
	endtask : pulse

	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			end_of_test();
		end
	end

	// Main sequence
	initial begin
		seed = 32'h25723304;
		{sys_clk, rst_n, pcie_reset_n, global_reset_n} = '0;
		cfg_req = '0;
		corr_evt = '0;
		{corr_mask, uncorr_evt, uncorr_mask} = '0;
		exp_sev = aer_pkg::AER_SEV_RESET | aer_pkg::AER_SEV_RO_ONES;
		exp_sts = '0;
		repeat (2) @(posedge sys_clk);
		#1;
		{rst_n, pcie_reset_n, global_reset_n} = 3'h7;
		cfg_read_chk(12'h10c, 32'h0006_2031);
		cfg_read_chk(12'h110, 32'h0000_0000);
		cfg_write(12'h114, 32'hffff_ffff, 4'hf);
		cfg_read_chk(12'h108, 32'h0000_0000);
		cfg_write(12'h10c, 32'hffff_ffff, 4'hf);
		cfg_read_chk(12'h10c, 32'h001f_f031);
		cfg_write(12'h10c, 32'h0000_0000, 4'hf);
		cfg_read_chk(12'h10c, 32'h0000_0021);
		exp_sev = 32'h0000_0021;
		// Random severity with uncorrectable events
		for (int k = 0; k < 40; k++) begin
			w = $random(seed);
			b = 4'($random(seed));
			cfg_write(12'h10c, w, b);
			exp_sev = sev_next(exp_sev, w, b);
			uncorr_mask = $random(seed) & $random(seed);
			u = (k < 10) ? (32'h1 << (k + 11)) : $random(seed);
			pulse('0, u);
			s = u & ~uncorr_mask & aer_pkg::AER_SEV_WR_MASK;
			chk("msg_fatal", {31'h0, |(s & exp_sev)}, {31'h0, msg_fatal});
			chk("msg_nonfatal", {31'h0, |(s & ~exp_sev)}, {31'h0, msg_nonfatal});
			chk("cfg_rvalid", 32'h0, {31'h0, cfg_rvalid});
			chk("severity", exp_sev, severity);
			cfg_read_chk(12'h10c, exp_sev);
		end
		// Correctable events, masking and write-one-clear
		for (int k = 0; k < 60; k++) begin
			if (k == 6) begin
				cfg_write(12'h110, 32'hffff_ffff, 4'hf);
				exp_sts = '0;
				corr_mask = 32'hffff_ffff;
			end else begin
				corr_mask = (k < 6) ? 32'h0 : ($random(seed) & $random(seed));
			end
			ev = (k < 6) ? (6'h1 << k) : ((k == 6) ? 6'h3f : 6'($random(seed)));
			pulse(ev, '0);
			s = evt_bits(ev, corr_mask);
			chk("msg_correctable", {31'h0, |s}, {31'h0, msg_correctable});
			exp_sts = exp_sts | s;
			cfg_read_chk(12'h110, exp_sts);
			chk("corr_status", exp_sts, corr_status);
			if (k % 3 == 2) begin
				w = $random(seed);
				b = 4'($random(seed));
				cfg_write(12'h110, w, b);
				exp_sts = exp_sts & ~(w & lane_mask(b));
				cfg_read_chk(12'h110, exp_sts);
			end
		end
		// Ordinary reset keeps sticky bits; each fundamental reset clears all
		for (int r = 0; r < 3; r++) begin
			corr_mask = '0;
			pulse(6'h3f, '0);
			cfg_write(12'h10c, 32'h0000_0000, 4'hf);
			exp_sev = 32'h0000_0021;
			@(posedge sys_clk);
			#1;
			{rst_n, pcie_reset_n, global_reset_n} = ~(3'h4 >> r);
			@(posedge sys_clk);
			#1;
			{rst_n, pcie_reset_n, global_reset_n} = 3'h7;
			exp_sts = (r == 0) ? 32'h0000_11c1 : 32'h0;
			exp_sev = (r == 0) ? exp_sev : 32'h0006_2031;
			cfg_read_chk(12'h110, exp_sts);
			cfg_read_chk(12'h10c, exp_sev);
		end
		end_of_test();
	end
endmodule : tb_pcie_aer_severity_corr_status
`default_nettype wire
